// file: src/rgb_led_command_dimmer.sv
// Write-only serial command decoder with gradual dimming engine
`timescale 1ns/1ps
`include "rgb_led_consts.svh"
module rgb_led_command_dimmer #(
  parameter int unsigned UNIT_CYCLES = `RAMP_UNIT_MS * `CLK_FREQ_KHZ
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic [4:0]      led_current_level_o,
  output logic [2:0]      led_on_o,
  output logic            ramp_busy_o
);
  import rgb_led_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds stage two only
  logic [1:0] scl_s_r, sda_s_r;
  logic       scl_d_r, sda_d_r;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  // Edges seen on the settled copies only
  assign scl_rise = scl_s_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_s_r[1] & scl_d_r;
  assign start_ev = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  assign stop_ev  = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // Link state machine
  link_state_e st_r, st_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic        ack_r, ack_nxt;
  logic        stb_r, stb_nxt;
  logic [7:0]  cmd_r, cmd_nxt;

  // Start always restarts the frame so a glitched frame cannot wedge the link
  always_comb
  begin
    st_nxt    = st_r;
    shift_nxt = shift_r;
    bit_nxt   = bit_r;
    ack_nxt   = ack_r;
    stb_nxt   = 1'b0;
    cmd_nxt   = cmd_r;
    if (start_ev)
    begin
      st_nxt  = ST_ADDR;
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
    end
    else if (stop_ev)
    begin
      st_nxt  = ST_IDLE;
      ack_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        ST_ADDR, ST_CMD:
        begin
          if (scl_rise && bit_r != `BITS_PER_BYTE)
          begin
            shift_nxt = {shift_r[6:0], sda_s_r[1]};
            bit_nxt   = bit_r + 4'h1;
          end
          else if (scl_fall && bit_r == `BITS_PER_BYTE)
          begin
            if (st_r == ST_CMD)
            begin
              st_nxt  = ST_ACK_C;
              ack_nxt = 1'b1;
              stb_nxt = 1'b1;
              cmd_nxt = shift_r;
            end
            else if (shift_r == `ADDR_BYTE)
            begin
              st_nxt  = ST_ACK_A;
              ack_nxt = 1'b1;
            end
            else
            begin
              st_nxt = ST_SKIP;
            end
          end
        end
        ST_ACK_A:
        begin
          if (scl_fall)
          begin
            st_nxt  = ST_CMD;
            bit_nxt = 4'h0;
            ack_nxt = 1'b0;
          end
        end
        ST_ACK_C:
        begin
          // Only one command byte per frame; later bytes are not acknowledged
          if (scl_fall)
          begin
            st_nxt  = ST_SKIP;
            ack_nxt = 1'b0;
          end
        end
        default:
        begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r    <= ST_IDLE;
      shift_r <= 8'h00;
      bit_r   <= 4'h0;
      ack_r   <= 1'b0;
      stb_r   <= 1'b0;
      cmd_r   <= 8'h00;
    end
    else
    begin
      st_r    <= st_nxt;
      shift_r <= shift_nxt;
      bit_r   <= bit_nxt;
      ack_r   <= ack_nxt;
      stb_r   <= stb_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parameter registers and dimming engine
  logic [2:0] func;
  step_t      pay;
  assign func = cmd_r[7:5];
  assign pay  = cmd_r[4:0];

  step_t       level_r, level_nxt;
  step_t       duty_r [3], duty_nxt [3];
  step_t       rise_r, rise_nxt, fall_r, fall_nxt;
  step_t       time_r, time_nxt, tgt_r, tgt_nxt, scnt_r, scnt_nxt;
  logic        up_r, up_nxt, run_r, run_nxt, shut_r, shut_nxt;
  logic [19:0] ucnt_r, ucnt_nxt;
  logic        step_ev;

  // A step is due when enough 8 ms units have passed; zero acts as one unit
  assign step_ev = run_r && (ucnt_r == 20'(UNIT_CYCLES - 1))
                   && (scnt_r + 5'h01 >= time_r);

  always_comb
  begin
    level_nxt = level_r;
    rise_nxt  = rise_r;
    fall_nxt  = fall_r;
    time_nxt  = time_r;
    tgt_nxt   = tgt_r;
    up_nxt    = up_r;
    run_nxt   = run_r;
    shut_nxt  = shut_r;
    scnt_nxt  = scnt_r;
    ucnt_nxt  = ucnt_r;
    for (int i = 0; i < 3; i++)
    begin
      duty_nxt[i] = duty_r[i];
    end
    // Interval timer runs only during a ramp
    if (run_r)
    begin
      if (ucnt_r == 20'(UNIT_CYCLES - 1))
      begin
        ucnt_nxt = 20'h0_0000;
        scnt_nxt = step_ev ? 5'h00 : scnt_r + 5'h01;
      end
      else
      begin
        ucnt_nxt = ucnt_r + 20'h0_0001;
      end
    end
    // Wrap stays inside 0..31, so no step ever leaves the legal range
    if (run_r && level_r == tgt_r)
    begin
      run_nxt = 1'b0;
    end
    else if (step_ev && up_r)
    begin
      level_nxt = (level_r == `STEP_MAX) ? 5'h00 : level_r + 5'h01;
    end
    else if (step_ev)
    begin
      level_nxt = (level_r == 5'h00) ? `STEP_MAX : level_r - 5'h01;
    end
    if (stb_r)
    begin
      shut_nxt = (func == `FUNC_SHUTDOWN);
      case (func)
        `FUNC_PEAK:
        begin
          level_nxt = pay;
          run_nxt   = 1'b0;
        end
        `FUNC_DUTY1: duty_nxt[0] = pay;
        `FUNC_DUTY2: duty_nxt[1] = pay;
        `FUNC_DUTY3: duty_nxt[2] = pay;
        `FUNC_RISE:
        begin
          rise_nxt = pay;
          up_nxt   = 1'b1;
        end
        `FUNC_FALL:
        begin
          fall_nxt = pay;
          up_nxt   = 1'b0;
        end
        `FUNC_RAMP:
        begin
          time_nxt = pay;
          tgt_nxt  = up_r ? rise_r : fall_r;
          run_nxt  = 1'b1;
          ucnt_nxt = 20'h0_0000;
          scnt_nxt = 5'h00;
        end
        default:
        begin
          run_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      level_r <= `REG_RESET;
      rise_r  <= `REG_RESET;
      fall_r  <= `REG_RESET;
      time_r  <= `REG_RESET;
      tgt_r   <= `REG_RESET;
      scnt_r  <= `REG_RESET;
      ucnt_r  <= 20'h0_0000;
      up_r    <= 1'b0;
      run_r   <= 1'b0;
      shut_r  <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        duty_r[i] <= `REG_RESET;
      end
    end
    else
    begin
      level_r <= level_nxt;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
      time_r  <= time_nxt;
      tgt_r   <= tgt_nxt;
      scnt_r  <= scnt_nxt;
      ucnt_r  <= ucnt_nxt;
      up_r    <= up_nxt;
      run_r   <= run_nxt;
      shut_r  <= shut_nxt;
      for (int i = 0; i < 3; i++)
      begin
        duty_r[i] <= duty_nxt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output stage: duty modulation over a 31-count period
  logic [4:0] pwm_r, pwm_nxt, out_lvl_nxt;
  logic [2:0] on_nxt;

  // Period of 31 counts makes duty 31 always on and duty 0 always off
  always_comb
  begin
    pwm_nxt = (pwm_r == `PWM_LAST) ? 5'h00 : pwm_r + 5'h01;
    if (shut_r)
    begin
      out_lvl_nxt = 5'h00;
    end
    else if (level_r == `STEP_MAX)
    begin
      out_lvl_nxt = `STEP_SAT;
    end
    else
    begin
      out_lvl_nxt = level_r;
    end
    for (int i = 0; i < 3; i++)
    begin
      on_nxt[i] = !shut_r && (level_r != 5'h00)
                  && (duty_r[i] > pwm_r);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pwm_r               <= 5'h00;
      led_current_level_o <= 5'h00;
      led_on_o            <= 3'h0;
      ramp_busy_o         <= 1'b0;
      sda_o               <= 1'b1;
      sda_oe_n_o          <= 1'b1;
    end
    else
    begin
      pwm_r               <= pwm_nxt;
      led_current_level_o <= out_lvl_nxt;
      led_on_o            <= on_nxt;
      ramp_busy_o         <= run_r;
      sda_o               <= ~ack_nxt;
      sda_oe_n_o          <= ~ack_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_SHUT_ZERO: assert property (shut_r
    |=> led_current_level_o == 5'h00)
    else $error("current not zero in shutdown");
  AST_PEAK_DIRECT: assert property (stb_r && func == `FUNC_PEAK
    |=> level_r == $past(pay) && !run_r)
    else $error("peak step not applied at acknowledge");
  AST_DUTY_KEEP: assert property (run_r && !stb_r
    |=> $stable(duty_r[0]) && $stable(duty_r[1]) && $stable(duty_r[2]))
    else $error("duty changed by ramp");
  AST_DUTY_OFF: assert property (duty_r[1] == 5'h00
    |=> !led_on_o[1])
    else $error("led on with zero duty");
  AST_LEVEL_SAT: assert property (led_current_level_o <= `STEP_SAT)
    else $error("level above saturation");
  AST_RAMP_START: assert property (stb_r && func == `FUNC_RAMP
    |=> run_r && time_r == $past(pay))
    else $error("ramp did not start");
  AST_STEP_UP: assert property (step_ev && up_r
    && level_r != tgt_r && !stb_r |=> level_r == $past(level_r) + 5'h01)
    else $error("rising step wrong");
  AST_STEP_DN: assert property (step_ev && !up_r
    && level_r != tgt_r && !stb_r |=> level_r == $past(level_r) - 5'h01)
    else $error("falling step wrong");
  AST_ACK_LOW: assert property (stb_r |-> !sda_oe_n_o && !sda_o)
    else $error("command applied without acknowledge");
  AST_RAMP_END: assert property (run_r && level_r == tgt_r
    && !stb_r |=> !run_r ##1 !ramp_busy_o)
    else $error("ramp not ended at target");
endmodule : rgb_led_command_dimmer

// file: src/rgb_led_consts.svh
// Constants for the three-channel LED command dimmer
`ifndef RGB_LED_CONSTS_SVH
`define RGB_LED_CONSTS_SVH
`define ADDR_BYTE      8'h70
`define FUNC_SHUTDOWN  3'h0
`define FUNC_PEAK      3'h1
`define FUNC_DUTY1     3'h2
`define FUNC_DUTY2     3'h3
`define FUNC_DUTY3     3'h4
`define FUNC_RISE      3'h5
`define FUNC_FALL      3'h6
`define FUNC_RAMP      3'h7
`define STEP_MAX       5'h1f
`define STEP_SAT       5'h1e
`define PWM_LAST       5'h1e
`define REG_RESET      5'h00
`define BITS_PER_BYTE  4'h8
`define RAMP_UNIT_MS   8
`define CLK_FREQ_KHZ   50000
`endif

// file: src/rgb_led_pkg.sv
// Types shared by the LED command dimmer
package rgb_led_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_ACK_A = 6'h04,
    ST_CMD   = 6'h08,
    ST_ACK_C = 6'h10,
    ST_SKIP  = 6'h20
  } link_state_e;
  typedef logic [4:0] step_t;
endpackage : rgb_led_pkg

// file: verif/i2c_ctrl_model.sv
// Serial bus controller model that writes frames to the dimmer
`timescale 1ns/1ps
module i2c_ctrl_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Quarter of the 160 ns serial period, launched just after an edge
  task automatic q();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : q
  // One bit; the wire is sampled mid-high so a late ack is still seen
  task automatic put(input logic b, output logic seen);
    scl_o = 1'b0;
    q();
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    seen = sda_i;
    q();
  endtask : put
  // Start, address, ack, command, ack, stop; clock idles high
  task automatic frame(input logic [7:0] a, input logic [7:0] c,
                       output logic ack_a, output logic ack_c);
    logic        s;
    logic [15:0] w;
    w = {a, c};
    q();
    sda_o = 1'b0;
    q();
    for (int i = 15; i >= 0; i--)
    begin
      put(w[i], s);
      if (i == 8)
      begin
        put(1'b1, s);
        ack_a = ~s;
      end
    end
    put(1'b1, s);
    ack_c = ~s;
    scl_o = 1'b0;
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1; // Released: pull-up brings the wire high
    q();
  endtask : frame
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
endmodule : i2c_ctrl_model

// file: verif/rgb_led_command_dimmer_bench.sv
// Self-checking bench for the LED command dimmer
`timescale 1ns/1ps
`include "rgb_led_consts.svh"
module rgb_led_command_dimmer_bench;
  import rgb_led_pkg::*;
  localparam int U = 20;
  logic       clk_i;
  logic       rstn_i;
  logic       scl;
  logic       m_sda;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe_n_o;
  step_t      lvl;
  step_t      prev;
  logic [2:0] led_on_o;
  logic       ramp_busy_o;
  int         failures;
  int         checks;
  int         busy_cnt;
  // Open-drain wire: either party may pull low
  assign sda_w = (sda_oe_n_o ? 1'b1 : sda_o) & m_sda;
  rgb_led_command_dimmer #(.UNIT_CYCLES(U)) rgb_led_command_dimmer_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .led_current_level_o(lvl),
    .led_on_o(led_on_o), .ramp_busy_o(ramp_busy_o));
  i2c_ctrl_model i2c_ctrl_model_i (
    .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // One frame to a given address, acks judged against expectation
  task automatic send(input logic [7:0] a, input logic [7:0] c, input logic e);
    logic aa;
    logic ac;
    i2c_ctrl_model_i.frame(a, c, aa, ac);
    chk("ack_addr", {7'h00, e}, {7'h00, aa});
    chk("ack_cmd", {7'h00, e}, {7'h00, ac});
    repeat (3) @(posedge clk_i);
    #1;
  endtask : send
  // Busy time and level steps; a jump other than one step or a wrap fails
  always @(posedge clk_i)
  begin
    if (ramp_busy_o === 1'b1)
      busy_cnt++;
    if (rstn_i && ramp_busy_o && lvl != prev && lvl != prev + 5'h01 &&
        lvl != prev - 5'h01 && !(lvl == 5'h00 && prev == `STEP_SAT) &&
        !(prev == 5'h00 && lvl == `STEP_SAT))
      chk("ramp_jump", {3'h0, prev}, {3'h0, lvl});
    prev <= lvl;
  end
  // Start level, target, run; time per step is pay units of U clocks
  task automatic ramp(input step_t s, input logic [7:0] t, input step_t pay,
                      input int n, input step_t e);
    int b;
    send(`ADDR_BYTE, {`FUNC_PEAK, s}, 1'b1);
    send(`ADDR_BYTE, t, 1'b1);
    b = busy_cnt;
    send(`ADDR_BYTE, {`FUNC_RAMP, pay}, 1'b1);
    chk("busy", 8'h01, {7'h00, ramp_busy_o});
    for (int i = 0; i < 4000 && ramp_busy_o !== 1'b0; i++)
      @(posedge clk_i);
    #1;
    b = busy_cnt - b - n * pay * U;
    chk("ramp_len", 8'h01, {7'h00, b >= -2 && b <= 4});
    chk("ramp_end", {3'h0, e}, {3'h0, lvl});
    chk("duty_kept", 8'h04, {5'h00, led_on_o});
  endtask : ramp
  // Each LED alone at full duty, the others at zero
  task automatic duty_scan();
    logic [2:0] an;
    logic [2:0] orv;
    for (int i = 0; i < 3; i++)
    begin
      for (int k = 0; k < 3; k++)
        send(`ADDR_BYTE, {3'(2 + k), (k == i) ? `STEP_MAX : 5'h00}, 1'b1);
      an = 3'h7;
      orv = 3'h0;
      repeat (40)
      begin
        @(posedge clk_i);
        an = an & led_on_o;
        orv = orv | led_on_o;
      end
      chk("led_all_on", {5'h00, 3'(1 << i)}, {5'h00, an});
      chk("led_any_on", {5'h00, 3'(1 << i)}, {5'h00, orv});
    end
  endtask : duty_scan
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn_i = 1'b0;
    failures = 0;
    checks = 0;
    busy_cnt = 0;
    repeat (6) @(posedge clk_i);
    #1;
    chk("level_rst", 8'h00, {3'h0, lvl});
    chk("led_rst", 8'h00, {5'h0, led_on_o});
    chk("busy_rst", 8'h00, {7'h0, ramp_busy_o});
    rstn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    send(8'h71, {`FUNC_PEAK, 5'h09}, 1'b0);
    send(8'h72, {`FUNC_PEAK, 5'h09}, 1'b0);
    chk("level_refused", 8'h00, {3'h0, lvl});
    send(`ADDR_BYTE, {`FUNC_PEAK, 5'h05}, 1'b1);
    chk("level_direct", 8'h05, {3'h0, lvl});
    chk("busy_direct", 8'h00, {7'h0, ramp_busy_o});
    send(`ADDR_BYTE, {`FUNC_PEAK, `STEP_MAX}, 1'b1);
    chk("level_31", {3'h0, `STEP_SAT}, {3'h0, lvl});
    duty_scan();
    send(`ADDR_BYTE, {`FUNC_SHUTDOWN, 5'h1f}, 1'b1);
    repeat (40) @(posedge clk_i);
    #1;
    chk("level_off", 8'h00, {3'h0, lvl});
    chk("led_off", 8'h00, {5'h0, led_on_o});
    send(`ADDR_BYTE, {`FUNC_RISE, 5'h08}, 1'b1);
    ramp(5'h05, {`FUNC_RISE, 5'h08}, 5'h01, 3, 5'h08);
    ramp(5'h1c, {`FUNC_RISE, 5'h02}, 5'h01, 6, 5'h02);
    ramp(5'h02, {`FUNC_FALL, 5'h1c}, 5'h02, 6, 5'h1c);
    summarize();
  end
  // Watchdog for a hung handshake or ramp
  initial
  begin
    #400000;
    failures++;
    summarize();
  end
endmodule : rgb_led_command_dimmer_bench
